//--- design/i2cdt_regs.vh
`ifndef I2CDT_REGS_VH
`define I2CDT_REGS_VH
// Target type codes carried in address byte bits 7..4.
`define I2CDT_ID_MEM 4'ha
`define I2CDT_ID_CMP 4'hd
// Highest valid companion register address.
`define I2CDT_CMP_LAST 8'h18
// Reset values of the two saved address latches.
`define I2CDT_MEM_ADDR_RST 15'h0000
`define I2CDT_CMP_ADDR_RST 8'h00
// Glitch filter length in REF_CLK cycles for the bus lines.
`define I2CDT_FILT_LEN 3
// REF_CLK cycles after each change of our own data drive during which bus conditions are ignored.
`define I2CDT_OWN_HOLD 4'ha
// Staging FIFO depth and its pointer width.
`define I2CDT_FIFO_DEPTH 16
`define I2CDT_FIFO_AW 4
`endif

//--- design/i2cdt_top.v
// Behaviour
// - Address byte upper nibble 1010b selects the memory target.
// - Address byte upper nibble 1101b selects the companion register target.
// - Companion transactions never write the memory array.
// - Respond only when address bits 2..1 match the two select straps.
// - Address bit 0 high means read, low means write.
// - SDA rising while SCL high is stop; abort any operation.
// - SDA falling while SCL high is start; abort and await address.
// - Supply below trip threshold aborts the current transaction.
// - SDA stable while SCL high; data sampled on SCL high.
// - Transmitter releases SDA on ninth clock; receiver drives low to acknowledge.
// - No acknowledge ends the operation; device waits to be addressed again.
// - Read: drive eight bits, sample acknowledge, continue on ack, stop on nack.
// - Write: receive eight bits, then drive acknowledge on the next clock.
// - All bytes are shifted most significant bit first.
// - Memory write takes two address bytes forming a 15-bit latch.
// - Memory address increments per data byte before ack, wrapping 7FFFh to 0000h.
// - Memory address is kept until rewritten or supply trips; reads use it.
// - Bursts have no length limit.
// - Write address then repeated start read reads from new address.
// - Companion takes one register address byte, 00h through 18h valid.
// - Companion address above 18h gets no acknowledge and aborts.
// - Memory writes have no busy period; device always acknowledges when addressed. A data byte is not acknowledged while the write FIFO is full.
// - Array write issued after eighth bit, before ack; aborts earlier write nothing.
// - Memory and companion keep separate saved addresses.
// - Companion address auto-increments after each transferred byte.
`timescale 1ns/1ps
`include "i2cdt_regs.vh"

module i2cdt_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst_n,
  input wire clr,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage is written without reset; only pointers and count need a defined value.
  always @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // Pointer and count update; clear drops pending entries.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (clr) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

module i2cdt_top (
  input wire REF_CLK,
  input wire RST_N,
  input wire SCL_IN,
  input wire SDA_IN,
  output wire SDA_OUT,
  output wire SDA_OE,
  input wire [1:0] SEL_PINS,
  input wire SUPPLY_LOW,
  output wire WR_VALID,
  input wire WR_READY,
  output wire WR_TARGET,
  output wire [14:0] WR_ADDR,
  output wire [7:0] WR_DATA,
  output reg RD_REQ,
  output reg RD_TARGET,
  output reg [14:0] RD_ADDR,
  input wire [7:0] RD_DATA,
  output wire BUSY
);
  localparam ST_IDLE = 3'h0;
  localparam ST_DEVADDR = 3'h1;
  localparam ST_ADDRHI = 3'h2;
  localparam ST_ADDRLO = 3'h3;
  localparam ST_WDATA = 3'h4;
  localparam ST_RDATA = 3'h5;

  reg [2:0] scl_s_r;
  reg [2:0] sda_s_r;
  reg [1:0] sup_s_r;
  reg [1:0] scl_cnt_r;
  reg [1:0] sda_cnt_r;
  reg scl_f_r;
  reg sda_f_r;
  reg scl_d_r;
  reg sda_d_r;
  reg [2:0] state_r;
  reg [3:0] bit_r;
  reg [7:0] shift_r;
  reg [7:0] tx_r;
  reg ack_phase_r;
  reg ack_drive_r;
  reg bit_drive_r;
  reg rise_seen_r;
  reg oe_d_r;
  reg [3:0] own_hold_r;
  reg is_cmp_r;
  reg [14:0] mem_addr_r;
  reg [7:0] cmp_addr_r;
  reg [6:0] hi_r;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire abort;
  wire [7:0] rx_byte;
  wire wr_push;
  wire fifo_ready;
  wire [23:0] fifo_out;
  wire [14:0] cur_addr;

  // Three flops per bus line, two for the supply; the third stage is the first one logic may read.
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      sup_s_r <= 2'h0;
    end else begin
      scl_s_r <= {scl_s_r[1:0], SCL_IN};
      sda_s_r <= {sda_s_r[1:0], SDA_IN};
      sup_s_r <= {sup_s_r[0], SUPPLY_LOW};
    end
  end

  // Straps sampled through two flops; kept apart from the line chains above.
  reg [1:0] sel_a_r;
  reg [1:0] sel_b_r;
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sel_a_r <= 2'h0;
      sel_b_r <= 2'h0;
    end else begin
      sel_a_r <= SEL_PINS;
      sel_b_r <= sel_a_r;
    end
  end

  // A line level is accepted only after it holds for the filter length, which rejects short spikes.
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_cnt_r <= 2'h0;
      sda_cnt_r <= 2'h0;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_f_r;
      sda_d_r <= sda_f_r;
      if (scl_s_r[2] == scl_f_r) begin
        scl_cnt_r <= 2'h0;
      end else if (scl_cnt_r == (`I2CDT_FILT_LEN - 1)) begin
        scl_cnt_r <= 2'h0;
        scl_f_r <= scl_s_r[2];
      end else begin
        scl_cnt_r <= scl_cnt_r + 2'h1;
      end
      if (sda_s_r[2] == sda_f_r) begin
        sda_cnt_r <= 2'h0;
      end else if (sda_cnt_r == (`I2CDT_FILT_LEN - 1)) begin
        sda_cnt_r <= 2'h0;
        sda_f_r <= sda_s_r[2];
      end else begin
        sda_cnt_r <= sda_cnt_r + 2'h1;
      end
    end
  end

  // Edge and condition detection on the filtered lines.
  assign scl_rise = scl_f_r & ~scl_d_r;
  assign scl_fall = ~scl_f_r & scl_d_r;
  assign start_det = scl_f_r & scl_d_r & sda_d_r & ~sda_f_r & (own_hold_r == 4'h0);
  assign stop_det = scl_f_r & scl_d_r & ~sda_d_r & sda_f_r & (own_hold_r == 4'h0);

  // Our own drive returns through the input filter late, often inside a high clock phase.
  // Conditions are ignored briefly after each change so the device never aborts itself.
  // Limitation: a real condition within that short window after our own edge is missed.
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      oe_d_r <= 1'b0;
      own_hold_r <= 4'h0;
    end else begin
      oe_d_r <= SDA_OE;
      if (SDA_OE != oe_d_r) begin
        own_hold_r <= `I2CDT_OWN_HOLD;
      end else if (own_hold_r != 4'h0) begin
        own_hold_r <= own_hold_r - 4'h1;
      end
    end
  end
  assign abort = start_det | stop_det | sup_s_r[1];
  assign rx_byte = {shift_r[6:0], sda_f_r};
  assign cur_addr = is_cmp_r ? {7'h00, cmp_addr_r} : mem_addr_r;

  // Main byte engine: bits taken at the end of the SCL high phase, SDA changed on SCL fall.
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= ST_IDLE;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ack_phase_r <= 1'b0;
      ack_drive_r <= 1'b0;
      bit_drive_r <= 1'b0;
      rise_seen_r <= 1'b0;
      is_cmp_r <= 1'b0;
      mem_addr_r <= `I2CDT_MEM_ADDR_RST;
      cmp_addr_r <= `I2CDT_CMP_ADDR_RST;
      hi_r <= 7'h00;
      RD_REQ <= 1'b0;
      RD_TARGET <= 1'b0;
      RD_ADDR <= 15'h0000;
    end else begin
      RD_REQ <= 1'b0;
      if (sup_s_r[1]) begin
        // Tripped supply loses the saved address as the array would.
        state_r <= ST_IDLE;
        ack_drive_r <= 1'b0;
        bit_drive_r <= 1'b0;
        mem_addr_r <= `I2CDT_MEM_ADDR_RST;
      end else if (start_det) begin
        state_r <= ST_DEVADDR;
        bit_r <= 4'h0;
        rise_seen_r <= 1'b0;
        ack_phase_r <= 1'b0;
        ack_drive_r <= 1'b0;
        bit_drive_r <= 1'b0;
      end else if (stop_det) begin
        state_r <= ST_IDLE;
        ack_drive_r <= 1'b0;
        bit_drive_r <= 1'b0;
      end else if (state_r != ST_IDLE) begin
        // Sampling at the fall sees our own earlier drive settled; at the rise it may still be in the filter.
        // The fall that ends a start condition follows no rise and carries no bit.
        if (scl_rise) begin
          rise_seen_r <= 1'b1;
        end
        if (scl_fall && rise_seen_r) begin
          if (!ack_phase_r && bit_r != 4'h7) begin
            shift_r <= rx_byte;
            bit_r <= bit_r + 4'h1;
            if (state_r == ST_RDATA) begin
              bit_drive_r <= ~tx_r[7];
              tx_r <= {tx_r[6:0], 1'b0};
            end
          end else if (!ack_phase_r) begin
            // Eighth bit complete: decide the acknowledge slot.
            shift_r <= rx_byte;
            ack_phase_r <= 1'b1;
            bit_r <= 4'h0;
            bit_drive_r <= 1'b0;
            ack_drive_r <= 1'b0;
            case (state_r)
              ST_DEVADDR: begin
                if ((rx_byte[7:4] == `I2CDT_ID_MEM || rx_byte[7:4] == `I2CDT_ID_CMP)
                    && rx_byte[2:1] == sel_b_r) begin
                  ack_drive_r <= 1'b1;
                  is_cmp_r <= (rx_byte[7:4] == `I2CDT_ID_CMP);
                  if (rx_byte[0]) begin
                    state_r <= ST_RDATA;
                  end else if (rx_byte[7:4] == `I2CDT_ID_CMP) begin
                    state_r <= ST_ADDRLO;
                  end else begin
                    state_r <= ST_ADDRHI;
                  end
                end else begin
                  state_r <= ST_IDLE;
                end
              end
              ST_ADDRHI: begin
                hi_r <= rx_byte[6:0];
                ack_drive_r <= 1'b1;
                state_r <= ST_ADDRLO;
              end
              ST_ADDRLO: begin
                if (is_cmp_r) begin
                  if (rx_byte > `I2CDT_CMP_LAST) begin
                    state_r <= ST_IDLE;
                  end else begin
                    cmp_addr_r <= rx_byte;
                    ack_drive_r <= 1'b1;
                    state_r <= ST_WDATA;
                  end
                end else begin
                  mem_addr_r <= {hi_r, rx_byte};
                  ack_drive_r <= 1'b1;
                  state_r <= ST_WDATA;
                end
              end
              ST_WDATA: begin
                // Written byte leaves with its address; ack only if the FIFO took it.
                ack_drive_r <= fifo_ready;
                if (is_cmp_r) begin
                  cmp_addr_r <= (cmp_addr_r == `I2CDT_CMP_LAST) ? 8'h00 : cmp_addr_r + 8'h01;
                end else begin
                  mem_addr_r <= mem_addr_r + 15'h0001;
                end
              end
              ST_RDATA: begin
                if (is_cmp_r) begin
                  cmp_addr_r <= (cmp_addr_r == `I2CDT_CMP_LAST) ? 8'h00 : cmp_addr_r + 8'h01;
                end else begin
                  mem_addr_r <= mem_addr_r + 15'h0001;
                end
              end
              default: begin
                state_r <= ST_IDLE;
              end
            endcase
          end else if (ack_phase_r) begin
            // End of the acknowledge clock.
            ack_phase_r <= 1'b0;
            ack_drive_r <= 1'b0;
            if (state_r == ST_RDATA) begin
              if (sda_f_r) begin
                state_r <= ST_IDLE;
                bit_drive_r <= 1'b0;
              end else begin
                bit_drive_r <= ~RD_DATA[7];
                tx_r <= {RD_DATA[6:0], 1'b0};
              end
            end else if (!ack_drive_r) begin
              state_r <= ST_IDLE;
            end
          end
        end
        // Fetch the next read byte during the acknowledge clock's high phase.
        if (scl_rise && ack_phase_r && (state_r == ST_RDATA || state_r == ST_DEVADDR)) begin
          RD_REQ <= 1'b1;
          RD_TARGET <= is_cmp_r;
          RD_ADDR <= cur_addr;
        end
      end
    end
  end

  // Data line only ever pulled low; released in every other slot.
  assign SDA_OUT = 1'b0;
  assign SDA_OE = ack_drive_r | bit_drive_r;
  assign BUSY = (state_r != ST_IDLE);

  // Write bytes pushed when the acknowledge slot begins for a data byte.
  assign wr_push = scl_fall & rise_seen_r & ~ack_phase_r & (bit_r == 4'h7) & (state_r == ST_WDATA)
    & ~abort & ~sup_s_r[1];

  i2cdt_fifo #(
    .WIDTH(24),
    .DEPTH(`I2CDT_FIFO_DEPTH),
    .AW(`I2CDT_FIFO_AW)
  ) u_fifo (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .clr(1'b0),
    .in_valid(wr_push),
    .in_ready(fifo_ready),
    .in_data({is_cmp_r, cur_addr, rx_byte}),
    .out_valid(WR_VALID),
    .out_ready(WR_READY),
    .out_data(fifo_out)
  );

  // Companion entries carry their register address in the low byte of the address field.
  assign WR_TARGET = fifo_out[23];
  assign WR_ADDR = fifo_out[22:8];
  assign WR_DATA = fifo_out[7:0];
endmodule

//--- verification/i2cdt_asserts.sv
`timescale 1ns/1ps
module i2cdt_asserts (
  input wire REF_CLK,
  input wire RST_N,
  input wire SCL_IN,
  input wire SDA_IN,
  input wire SDA_OUT,
  input wire SDA_OE,
  input wire SUPPLY_LOW,
  input wire WR_VALID,
  input wire WR_READY,
  input wire WR_TARGET,
  input wire [14:0] WR_ADDR,
  input wire [7:0] WR_DATA,
  input wire RD_REQ,
  input wire [14:0] RD_ADDR,
  input wire BUSY
);
  reg [1:0] scl_r;
  reg [1:0] sda_r;
  // A short view of the bus lines of our own, so conditions are judged apart from the design's filter.
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_r <= 2'b11;
      sda_r <= 2'b11;
    end else begin
      scl_r <= {scl_r[0], SCL_IN};
      sda_r <= {sda_r[0], SDA_IN};
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // A rise caused by the device letting go of its own low is not a stop.
  sequence s_stop;
    scl_r[1] && $rose(sda_r[1]) && !$past(SDA_OE, 4);
  endsequence
  sequence s_start;
    scl_r[1] && $fell(sda_r[1]) && !SDA_OE;
  endsequence
  a_oe_low_only: assert property (SDA_OE |-> !SDA_OUT)
    else $error("Data pin driven high.");
  a_stop_abort: assert property (s_stop |-> ##[1:10] (!BUSY && !SDA_OE))
    else $error("Stop did not end the transfer.");
  a_start_release: assert property (s_start |-> ##[1:10] !SDA_OE)
    else $error("Data pin held after start.");
  a_supply_abort: assert property (SUPPLY_LOW [*6] |-> (!BUSY && !SDA_OE))
    else $error("Transfer survived a supply trip.");
  a_rdreq_pulse: assert property (RD_REQ |=> !RD_REQ)
    else $error("Read request longer than one cycle.");
  a_rdreq_busy: assert property (RD_REQ |-> BUSY)
    else $error("Read request while idle.");
  a_rdaddr_hold: assert property ($changed(RD_ADDR) |-> RD_REQ)
    else $error("Read address moved without a request.");
  a_wr_hold: assert property (WR_VALID && !WR_READY |=> WR_VALID && $stable({WR_TARGET, WR_ADDR, WR_DATA}))
    else $error("Write entry changed while stalled.");
  a_cmp_range: assert property (WR_VALID && WR_TARGET |-> WR_ADDR <= 15'h0018)
    else $error("Companion write beyond last register.");
endmodule
bind i2cdt_top i2cdt_asserts u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SUPPLY_LOW(SUPPLY_LOW), .WR_VALID(WR_VALID), .WR_READY(WR_READY),
  .WR_TARGET(WR_TARGET), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .RD_REQ(RD_REQ), .RD_ADDR(RD_ADDR), .BUSY(BUSY));

//--- verification/i2cdt_host.sv
`timescale 1ns/1ps
module i2cdt_host (
  output reg scl,
  output reg sda_m,
  input wire sda_w
);
  // Both lines rest released; the clock stands high between frames.
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // One bit: data moves mid-low, holds through the high phase and is sampled just before the fall.
  task bitx(input b, output r);
    begin
      sda_m = b;
      #50 scl = 1'b1;
      #95 r = sda_w;
      #5 scl = 1'b0;
      #50;
    end
  endtask
  // Extra low time lets the device release an acknowledge, and its own filter settle, before the start.
  task start;
    begin
      sda_m = 1'b1;
      #300 scl = 1'b1;
      #100 sda_m = 1'b0;
      #50 scl = 1'b0;
      #50;
    end
  endtask
  task stop;
    begin
      sda_m = 1'b0;
      #50 scl = 1'b1;
      #50 sda_m = 1'b1;
      #100;
    end
  endtask
  task wbyte(input [7:0] d, output ack);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) bitx(d[i], r);
      bitx(1'b1, r);
      ack = !r;
    end
  endtask
  // The last wanted byte is left without an acknowledge, or the device keeps driving.
  task rbyte(input ack, output [7:0] d);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bitx(1'b1, r);
        d[i] = r;
      end
      bitx(!ack, r);
    end
  endtask
endmodule

//--- verification/i2cdt_tb_top.sv
`timescale 1ns/1ps
module i2cdt_tb_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg supply_low = 1'b0;
  reg wr_ready = 1'b1;
  reg [7:0] rd_data = 8'h00;
  wire scl, sda_m, sda_out, sda_oe, wr_valid, wr_target, rd_req, rd_target, busy;
  wire [14:0] wr_addr, rd_addr;
  wire [7:0] wr_data;
  wire sda_w = sda_m & (sda_oe ? sda_out : 1'b1);
  integer bad_count = 0;
  integer n_compared = 0;
  integer i;
  reg ak;
  reg [7:0] rb;
  reg [23:0] wq [$];
  localparam [17:0] ROWS [0:7] = '{{8'ha4, 8'h00, 2'b11}, {8'hd4, 8'h18, 2'b11}, {8'hd4, 8'h19, 2'b10},
    {8'hd4, 8'h00, 2'b11}, {8'ha0, 8'h00, 2'b00}, {8'ha6, 8'h00, 2'b00}, {8'hb4, 8'h00, 2'b00}, {8'h54, 8'h00, 2'b00}};
  initial forever #12.5 clk = ~clk;
  i2cdt_top u_dut (.REF_CLK(clk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .SEL_PINS(2'b10), .SUPPLY_LOW(supply_low), .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_TARGET(wr_target),
    .WR_ADDR(wr_addr), .WR_DATA(wr_data), .RD_REQ(rd_req), .RD_TARGET(rd_target), .RD_ADDR(rd_addr),
    .RD_DATA(rd_data), .BUSY(busy));
  i2cdt_host u_host (.scl(scl), .sda_m(sda_m), .sda_w(sda_w));
  // The array stands outside the block, so read data is a fixed function of target and address.
  function [7:0] f(input t, input [14:0] a);
    f = a[7:0] + {t, a[14:8]};
  endfunction
  always @(posedge clk) if (rd_req) rd_data <= #1 f(rd_target, rd_addr);
  // Consumer of the write FIFO; every popped entry is kept for comparison.
  always @(posedge clk) if (wr_valid && wr_ready) wq.push_back({wr_target, wr_addr, wr_data});
  task chk(input [23:0] seen, input [23:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task conclude;
    begin
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // A missing entry counts against the run instead of hanging it.
  task pop(input [23:0] exp);
    integer k;
    begin
      for (k = 0; k < 400 && wq.size() == 0; k = k + 1) @(posedge clk);
      if (wq.size() == 0) begin
        bad_count = bad_count + 1;
        conclude;
      end else chk(wq.pop_front(), exp);
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    chk(24'({busy, sda_oe, wr_valid, rd_req}), 24'h0);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge clk);
    // Address byte decoding and companion register address range.
    for (i = 0; i < 8; i = i + 1) begin
      u_host.start;
      u_host.wbyte(ROWS[i][17:10], ak);
      chk(24'(ak), 24'(ROWS[i][1]));
      if (ak) begin
        u_host.wbyte(ROWS[i][9:2], ak);
        chk(24'(ak), 24'(ROWS[i][0]));
      end
      u_host.stop;
    end
    // Stalled consumer: sixteen bytes fill the FIFO across the address wrap, the next is refused.
    @(posedge clk) #1 wr_ready = 1'b0;
    u_host.start;
    u_host.wbyte(8'ha4, ak);
    u_host.wbyte(8'h7f, ak);
    u_host.wbyte(8'hff, ak);
    for (i = 0; i < 17; i = i + 1) begin
      u_host.wbyte(8'(i), ak);
      chk(24'(ak), 24'(i < 16));
    end
    u_host.stop;
    @(posedge clk) #1 wr_ready = 1'b1;
    for (i = 0; i < 16; i = i + 1) pop({1'b0, 15'(i + 32767), 8'(i)});
    // A byte cut short by a stop writes nothing; the companion write that follows is the next entry.
    u_host.start;
    u_host.wbyte(8'ha4, ak);
    u_host.wbyte(8'h00, ak);
    u_host.wbyte(8'h20, ak);
    for (i = 0; i < 4; i = i + 1) u_host.bitx(1'b1, ak);
    u_host.stop;
    u_host.start;
    u_host.wbyte(8'hd4, ak);
    u_host.wbyte(8'h03, ak);
    u_host.wbyte(8'haa, ak);
    u_host.stop;
    pop({1'b1, 15'h0003, 8'haa});
    // Selective read through a repeated start, then each target resumes from its own address.
    u_host.start;
    u_host.wbyte(8'ha4, ak);
    u_host.wbyte(8'h12, ak);
    u_host.wbyte(8'h34, ak);
    u_host.start;
    u_host.wbyte(8'ha5, ak);
    u_host.rbyte(1'b1, rb);
    chk(24'(rb), 24'(f(1'b0, 15'h1234)));
    u_host.rbyte(1'b0, rb);
    chk(24'(rb), 24'(f(1'b0, 15'h1235)));
    u_host.stop;
    u_host.start;
    u_host.wbyte(8'hd5, ak);
    u_host.rbyte(1'b0, rb);
    chk(24'(rb), 24'(f(1'b1, 15'h0004)));
    u_host.stop;
    u_host.start;
    u_host.wbyte(8'ha5, ak);
    u_host.rbyte(1'b0, rb);
    chk(24'(rb), 24'(f(1'b0, 15'h1236)));
    u_host.stop;
    // Supply trip in the middle of a read; the memory address falls back to zero.
    u_host.start;
    u_host.wbyte(8'ha5, ak);
    @(posedge clk) #1 supply_low = 1'b1;
    repeat (20) @(posedge clk);
    chk(24'({busy, sda_oe}), 24'h0);
    #1 supply_low = 1'b0;
    u_host.stop;
    u_host.start;
    u_host.wbyte(8'ha5, ak);
    u_host.rbyte(1'b0, rb);
    chk(24'(rb), 24'(f(1'b0, 15'h0000)));
    u_host.stop;
    conclude;
  end
endmodule
